// ===== src/tscc_pkg.sv
// package: constants for the five-channel timer status, counter and capture
// Summary of operation
// [RULE1] wrap flag sets on counter wrap either way
// [RULE2] flag clears by read-one then write-zero
// [RULE3] written ones never change a flag
// [RULE4] compare B match sets flag B
// [RULE5] capture into register B sets flag B
// [RULE6] compare A match sets flag A
// [RULE7] capture into register A sets flag A
// [RULE8] capture latches full counter value
// [RULE9] software compare value drives match event
// [RULE10] counter resets zero, generals reset all ones
// [RULE11] status bits 6..3 read one, bit 7 undefined
package tscc_pkg;
  localparam int NUM_CH = 5;
  localparam int ADDR_W = 28;
  // printed offsets, per channel
  localparam logic [27:0] FLAGS_OFS [5] = '{28'h5ff_ff07, 28'h5ff_ff11,
    28'h5ff_ff1b, 28'h5ff_ff25, 28'h5ff_ff35};
  localparam logic [27:0] CNT_OFS [5] = '{28'h5ff_ff08, 28'h5ff_ff12,
    28'h5ff_ff1c, 28'h5ff_ff26, 28'h5ff_ff36};
  localparam logic [27:0] GEN_A_OFS [5] = '{28'h5ff_ff0a, 28'h5ff_ff14,
    28'h5ff_ff1e, 28'h5ff_ff28, 28'h5ff_ff38};
  localparam logic [27:0] GEN_B_OFS [5] = '{28'h5ff_ff0c, 28'h5ff_ff16,
    28'h5ff_ff20, 28'h5ff_ff2a, 28'h5ff_ff3a};
  // interrupt status and mask, one bit per flag, 3 per channel
  localparam logic [27:0] IRQ_STAT_OFS = 28'h5ff_ff80;
  localparam logic [27:0] IRQ_MASK_OFS = 28'h5ff_ff84;
  localparam int IRQ_W = 15;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_B_BIT = 1;
  localparam int WRAP_BIT = 2;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GEN_RST = 16'hffff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [7:0] FLAGS_FIXED = 8'h78;
  localparam logic [14:0] MASK_RST = 15'h0000;
endpackage : tscc_pkg

// ===== src/tscc_sync.sv
// module: three-flop input synchroniser with edge report
`timescale 1ns/100ps
module tscc_sync (
  input wire logic CLK, // clock
  input wire logic RESET, // sync reset
  input wire logic pin, // asynchronous input
  output logic rise, // one-cycle pulse on a qualified rise
  output logic fall // one-cycle pulse on a qualified fall
);
  logic [2:0] s_q;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_q <= 3'h0;
    end else begin
      s_q <= {s_q[1:0], pin};
    end
  end
  // s_q[0] feeds only s_q[1]
  logic lvl_q;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      lvl_q <= 1'b0;
    end else if (s_q[1] == s_q[2]) begin
      lvl_q <= s_q[2];
    end
  end
  assign rise = (s_q[1] == s_q[2]) && s_q[2] && !lvl_q;
  assign fall = (s_q[1] == s_q[2]) && !s_q[2] && lvl_q;
endmodule : tscc_sync

// ===== src/tscc_channel.sv
// module: one timer channel with counter, general registers and flags
`timescale 1ns/100ps
module tscc_channel (
  input wire logic CLK, // clock
  input wire logic RESET, // sync reset
  input wire logic count_en, // count clock enable pulse
  input wire logic count_down, // count direction
  input wire logic cap_mode_a, // register a is capture latch
  input wire logic cap_mode_b, // register b is capture latch
  input wire logic cap_a, // capture pulse for a
  input wire logic cap_b, // capture pulse for b
  input wire logic [1:0] wr_sel, // 0 flags 1 counter 2 a 3 b
  input wire logic wr_en, // write strobe for this channel
  input wire logic [15:0] wdata, // write data
  input wire logic [2:0] armed, // flag bits read as one before
  output logic [15:0] cnt, // counter value
  output logic [15:0] gen_a, // general register a
  output logic [15:0] gen_b, // general register b
  output logic [2:0] flags, // b2 wrap, b1 flag b, b0 flag a
  output logic [2:0] events, // one-cycle set pulses
  output logic match_a, // compare match a pulse
  output logic match_b // compare match b pulse
);
  logic [15:0] cnt_q;
  logic [15:0] gen_a_q;
  logic [15:0] gen_b_q;
  logic [2:0] flags_q;
  logic wrap;
  logic [2:0] clr;
  assign wrap = count_en && (count_down ? cnt_q == tscc_pkg::CNT_RST
    : cnt_q == tscc_pkg::CNT_MAX); // [RULE1]
  assign match_a = count_en && !cap_mode_a
    && cnt_q == gen_a_q; // [RULE6] [RULE9]
  assign match_b = count_en && !cap_mode_b
    && cnt_q == gen_b_q; // [RULE4] [RULE9]
  assign events = {wrap, match_b || (cap_mode_b && cap_b),
    match_a || (cap_mode_a && cap_a)}; // [RULE5] [RULE7]
  // clear needs a written zero on an armed bit; ones ignored
  assign clr = (wr_en && wr_sel == 2'd0) ? (~wdata[2:0] & armed)
    : 3'h0; // [RULE2] [RULE3]

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt_q <= tscc_pkg::CNT_RST; // [RULE10]
    end else if (wr_en && wr_sel == 2'd1) begin
      cnt_q <= wdata;
    end else if (count_en) begin
      cnt_q <= count_down ? cnt_q - 16'h0001 : cnt_q + 16'h0001; // [RULE1]
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      gen_a_q <= tscc_pkg::GEN_RST; // [RULE10]
    end else if (cap_mode_a && cap_a) begin
      gen_a_q <= cnt_q; // [RULE8]
    end else if (wr_en && wr_sel == 2'd2) begin
      gen_a_q <= wdata; // [RULE9]
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      gen_b_q <= tscc_pkg::GEN_RST; // [RULE10]
    end else if (cap_mode_b && cap_b) begin
      gen_b_q <= cnt_q; // [RULE8]
    end else if (wr_en && wr_sel == 2'd3) begin
      gen_b_q <= wdata; // [RULE9]
    end
  end

  // set wins over clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~clr) | events; // [RULE2]
    end
  end

  assign cnt = cnt_q;
  assign gen_a = gen_a_q;
  assign gen_b = gen_b_q;
  assign flags = flags_q;
endmodule : tscc_channel

// ===== src/tscc_top.sv
// module: five-channel timer status, counter and capture/compare block
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module tscc_top (
  input wire logic CLK, // 100 MHz clock
  input wire logic RESET, // sync reset, active high
  input wire logic [27:0] ADDR, // register address
  input wire logic [15:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [15:0] RDATA, // read data, cycle after RD
  input wire logic [4:0] COUNT_EN, // per-channel count enable pulses
  input wire logic [4:0] COUNT_DOWN, // per-channel count direction
  input wire logic [4:0] CAP_MODE_A, // register a capture mode select
  input wire logic [4:0] CAP_MODE_B, // register b capture mode select
  input wire logic [4:0] CAP_PIN_A, // capture input pins a
  input wire logic [4:0] CAP_PIN_B, // capture input pins b
  input wire logic [1:0] CAP_EDGE, // 0 rise 1 fall 2/3 both
  output logic [14:0] FLAGS, // all flags, 3 per channel
  output logic [4:0] MATCH_A, // compare match a pulses
  output logic [4:0] MATCH_B, // compare match b pulses
  output logic IRQ // level interrupt
);
  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  logic [15:0] cnt [5];
  logic [15:0] gen_a [5];
  logic [15:0] gen_b [5];
  logic [2:0] flags [5];
  logic [2:0] events [5];
  logic [2:0] armed_q [5];
  logic [4:0] hit_flags;
  logic [4:0] hit_cnt;
  logic [4:0] hit_gen_a;
  logic [4:0] hit_gen_b;
  logic [1:0] wr_sel [5];
  logic [14:0] ev_all;

  for (genvar c = 0; c < tscc_pkg::NUM_CH; c++) begin : g_ch
    logic ra;
    logic fa;
    logic rb;
    logic fb;
    assign hit_flags[c] = ADDR == tscc_pkg::FLAGS_OFS[c];
    assign hit_cnt[c] = ADDR == tscc_pkg::CNT_OFS[c];
    assign hit_gen_a[c] = ADDR == tscc_pkg::GEN_A_OFS[c];
    assign hit_gen_b[c] = ADDR == tscc_pkg::GEN_B_OFS[c];
    assign wr_sel[c] = hit_cnt[c] ? 2'd1 : hit_gen_a[c] ? 2'd2
      : hit_gen_b[c] ? 2'd3 : 2'd0;
    tscc_sync u_sa (
      .CLK(CLK),
      .RESET(RESET),
      .pin(CAP_PIN_A[c]),
      .rise(ra),
      .fall(fa)
    );
    tscc_sync u_sb (
      .CLK(CLK),
      .RESET(RESET),
      .pin(CAP_PIN_B[c]),
      .rise(rb),
      .fall(fb)
    );
    tscc_channel u_ch (
      .CLK(CLK),
      .RESET(RESET),
      .count_en(COUNT_EN[c]),
      .count_down(COUNT_DOWN[c]),
      .cap_mode_a(CAP_MODE_A[c]),
      .cap_mode_b(CAP_MODE_B[c]),
      .cap_a(edge_hit(CAP_EDGE, ra, fa)),
      .cap_b(edge_hit(CAP_EDGE, rb, fb)),
      .wr_sel(wr_sel[c]),
      .wr_en(WR && (hit_flags[c] || hit_cnt[c] || hit_gen_a[c]
        || hit_gen_b[c])),
      .wdata(WDATA),
      .armed(armed_q[c]),
      .cnt(cnt[c]),
      .gen_a(gen_a[c]),
      .gen_b(gen_b[c]),
      .flags(flags[c]),
      .events(events[c]),
      .match_a(MATCH_A[c]),
      .match_b(MATCH_B[c])
    );
    // a flag read as one arms its clear; a write to flags disarms, except in a cycle that also reads flags
    always_ff @(posedge CLK) begin
      if (RESET) begin
        armed_q[c] <= 3'h0;
      end else if (RD && hit_flags[c]) begin
        armed_q[c] <= armed_q[c] | flags[c]; // [RULE2]
      end else if (WR && hit_flags[c]) begin
        armed_q[c] <= 3'h0; // [RULE2]
      end
    end
    assign FLAGS[3*c +: 3] = flags[c];
    assign ev_all[3*c +: 3] = events[c];
  end

  function automatic logic edge_hit(input logic [1:0] sel,
    input logic r, input logic f);
    logic res;
    res = 1'b0;
    if (sel == 2'd0) begin
      res = r;
    end else if (sel == 2'd1) begin
      res = f;
    end else begin
      res = r || f;
    end
    return res;
  endfunction : edge_hit

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [14:0] stat_q;
  logic [14:0] mask_q;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stat_q <= 15'h0000;
    end else if (WR && ADDR == tscc_pkg::IRQ_STAT_OFS) begin
      stat_q <= (stat_q & ~WDATA[14:0]) | ev_all;
    end else begin
      stat_q <= stat_q | ev_all;
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mask_q <= tscc_pkg::MASK_RST;
    end else if (WR && ADDR == tscc_pkg::IRQ_MASK_OFS) begin
      mask_q <= WDATA[14:0];
    end
  end
  assign IRQ = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  always_comb begin
    rdata_d = 16'h0000;
    for (int c = 0; c < tscc_pkg::NUM_CH; c++) begin
      if (hit_flags[c]) begin
        // bit 7 undefined, returned as zero
        rdata_d = {8'h00, tscc_pkg::FLAGS_FIXED
          | {5'h00, flags[c]}}; // [RULE11]
      end else if (hit_cnt[c]) begin
        rdata_d = cnt[c];
      end else if (hit_gen_a[c]) begin
        rdata_d = gen_a[c];
      end else if (hit_gen_b[c]) begin
        rdata_d = gen_b[c];
      end
    end
    if (ADDR == tscc_pkg::IRQ_STAT_OFS) begin
      rdata_d = {1'b0, stat_q};
    end else if (ADDR == tscc_pkg::IRQ_MASK_OFS) begin
      rdata_d = {1'b0, mask_q};
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_q <= 16'h0000;
    end else if (RD) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign RDATA = rdata_q;
endmodule : tscc_top

// ===== bench/tscc_chk.sv
// checker: port-level assertions for the timer status block
`timescale 1ns/100ps
module tscc_chk (
  input wire logic CLK, // clock
  input wire logic RESET, // sync reset
  input wire logic [27:0] ADDR, // address
  input wire logic [15:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  input wire logic [15:0] RDATA, // read data
  input wire logic [4:0] COUNT_EN, // count enables
  input wire logic [4:0] CAP_MODE_A, // capture mode a
  input wire logic [4:0] CAP_MODE_B, // capture mode b
  input wire logic [14:0] FLAGS, // flags
  input wire logic [4:0] MATCH_A, // match a
  input wire logic [4:0] MATCH_B // match b
);
  // ----------------------------------------
  // channel 0 properties
  // ----------------------------------------
  logic fw;
  logic fr;
  assign fw = WR && ADDR == tscc_pkg::FLAGS_OFS[0];
  assign fr = RD && ADDR == tscc_pkg::FLAGS_OFS[0];
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  a_match_a_flag: assert property (MATCH_A[0] |=> FLAGS[0])
    else $error("match a did not set flag a");
  a_match_b_flag: assert property (MATCH_B[0] |=> FLAGS[1])
    else $error("match b did not set flag b");
  a_match_a_mode: assert property (MATCH_A[0] |-> COUNT_EN[0]
    && !CAP_MODE_A[0]) else $error("match a outside compare count");
  a_match_b_mode: assert property (MATCH_B[0] |-> COUNT_EN[0]
    && !CAP_MODE_B[0]) else $error("match b outside compare count");
  a_rdata_fixed: assert property (fr |=> RDATA[6:3] == 4'hf)
    else $error("fixed flag bits not one");
  a_write_one: assert property (fw && WDATA[2:0] == 3'b111
    |=> (FLAGS[2:0] | $past(FLAGS[2:0])) == FLAGS[2:0])
    else $error("writing ones cleared a flag");
  a_clear_cause: assert property ($fell(FLAGS[0]) |->
    $past(fw) && !$past(WDATA[0])) else $error("flag a cleared unasked");
  a_rose_cause: assert property ($rose(FLAGS[0]) |->
    $past(MATCH_A[0]) || $past(CAP_MODE_A[0]))
    else $error("flag a set without event");
endmodule : tscc_chk
bind tscc_top tscc_chk tscc_chk_inst (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .COUNT_EN(COUNT_EN),
  .CAP_MODE_A(CAP_MODE_A), .CAP_MODE_B(CAP_MODE_B), .FLAGS(FLAGS),
  .MATCH_A(MATCH_A), .MATCH_B(MATCH_B));

// ===== bench/tscc_top_tb.sv
// testbench: register-level scenarios for the timer status block
`timescale 1ns/100ps
module tscc_top_tb;
  // ----------------------------------------
  // signals and tasks
  // ----------------------------------------
  logic CLK, RESET, WR, RD, IRQ;
  logic [27:0] ADDR;
  logic [15:0] WDATA, RDATA;
  logic [4:0] COUNT_EN, COUNT_DOWN, CAP_MODE_A, CAP_MODE_B;
  logic [4:0] CAP_PIN_A, CAP_PIN_B, MATCH_A, MATCH_B;
  logic [1:0] CAP_EDGE;
  logic [14:0] FLAGS;
  int error_cnt, check_count;
  localparam logic [27:0] F0 = tscc_pkg::FLAGS_OFS[0];
  localparam logic [27:0] C0 = tscc_pkg::CNT_OFS[0];
  localparam logic [27:0] A0 = tscc_pkg::GEN_A_OFS[0];
  localparam logic [27:0] B0 = tscc_pkg::GEN_B_OFS[0];
  tscc_top tscc_top_inst (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .COUNT_EN(COUNT_EN),
    .COUNT_DOWN(COUNT_DOWN), .CAP_MODE_A(CAP_MODE_A),
    .CAP_MODE_B(CAP_MODE_B), .CAP_PIN_A(CAP_PIN_A), .CAP_PIN_B(CAP_PIN_B),
    .CAP_EDGE(CAP_EDGE), .FLAGS(FLAGS), .MATCH_A(MATCH_A),
    .MATCH_B(MATCH_B), .IRQ(IRQ));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic end_sim();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [27:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [27:0] a, input logic [15:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask : rd
  task automatic pulse(input int n, input logic [15:0] m);
    repeat (n) begin
      @(posedge CLK) COUNT_EN <= 5'h01;
      #1 chk({6'h00, MATCH_B, MATCH_A}, m);
      @(posedge CLK) COUNT_EN <= 5'h00;
    end
    #1;
  endtask : pulse
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    end_sim();
  end
  initial begin
    error_cnt = 0;
    check_count = 0;
    {RESET, WR, RD, ADDR, WDATA, COUNT_EN, COUNT_DOWN} = {1'b1, 56'h0};
    {CAP_MODE_A, CAP_MODE_B, CAP_PIN_A, CAP_PIN_B, CAP_EDGE} = 22'h0;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    for (int c = 0; c < 5; c++) begin
      rd(tscc_pkg::FLAGS_OFS[c], 16'h0078);
      rd(tscc_pkg::CNT_OFS[c], 16'h0000);
      rd(tscc_pkg::GEN_A_OFS[c], 16'hffff);
      rd(tscc_pkg::GEN_B_OFS[c], 16'hffff);
      wr(tscc_pkg::CNT_OFS[c], 16'h00c0 + 16'(c));
      rd(tscc_pkg::CNT_OFS[c], 16'h00c0 + 16'(c));
    end
    rd(28'h5ff_ff00, 16'h0000);
    wr(A0, 16'h0005);
    wr(C0, 16'h0003);
    pulse(2, 16'h0000);
    chk({13'h0, FLAGS[2:0]}, 16'h0000);
    pulse(1, 16'h0001);
    rd(C0, 16'h0006);
    rd(F0, 16'h0079);
    wr(F0, 16'h0007);
    chk({13'h0, FLAGS[2:0]}, 16'h0001);
    wr(F0, 16'h0000);
    chk({13'h0, FLAGS[2:0]}, 16'h0001);
    rd(F0, 16'h0079);
    wr(F0, 16'h0000);
    chk({13'h0, FLAGS[2:0]}, 16'h0000);
    wr(C0, 16'hffff);
    pulse(1, 16'h0020);
    rd(C0, 16'h0000);
    rd(F0, 16'h007e);
    wr(F0, 16'h0000);
    @(posedge CLK) COUNT_DOWN <= 5'h01;
    pulse(1, 16'h0000);
    rd(C0, 16'hffff);
    rd(F0, 16'h007c);
    wr(F0, 16'h0000);
    @(posedge CLK) CAP_MODE_A <= 5'h01;
    CAP_MODE_B <= 5'h01;
    wr(C0, 16'h0abc);
    @(posedge CLK) CAP_PIN_A <= 5'h01;
    repeat (6) @(posedge CLK);
    wr(C0, 16'h0def);
    @(posedge CLK) CAP_PIN_B <= 5'h01;
    repeat (6) @(posedge CLK);
    rd(A0, 16'h0abc);
    rd(B0, 16'h0def);
    rd(F0, 16'h007b);
    chk({15'h0, IRQ}, 16'h0000);
    wr(tscc_pkg::IRQ_MASK_OFS, 16'h0001);
    chk({15'h0, IRQ}, 16'h0001);
    wr(tscc_pkg::IRQ_STAT_OFS, 16'h7fff);
    chk({15'h0, IRQ}, 16'h0000);
    rd(tscc_pkg::IRQ_STAT_OFS, 16'h0000);
    rd(tscc_pkg::IRQ_MASK_OFS, 16'h0001);
    // falling-edge capture on a, then both-edge capture on b
    @(posedge CLK) CAP_EDGE <= 2'h1;
    wr(C0, 16'h0123);
    @(posedge CLK) CAP_PIN_A <= 5'h00;
    repeat (6) @(posedge CLK);
    rd(A0, 16'h0123);
    @(posedge CLK) CAP_EDGE <= 2'h2;
    wr(C0, 16'h0456);
    @(posedge CLK) CAP_PIN_B <= 5'h00;
    repeat (6) @(posedge CLK);
    rd(B0, 16'h0456);
    rd(A0, 16'h0123);
    end_sim();
  end
endmodule : tscc_top_tb
